// ==== design/rsx_pkg.sv ====
// Package for the shift/store/subtract execution slice of the core.
// Assumes a 16-bit instruction word and a 32-bit datapath.
package rsx_pkg;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [31:0] PUSH_STEP = 32'h0000_0004;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] LSB_MASK = 32'h0000_0001;
  localparam logic [31:0] HI24_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] HI16_MASK = 32'h0000_FFFF;
  // Narrow accumulator: sign bit position and width of the sign extension
  localparam int unsigned MAC_HIGH_SIGN_BIT = 9;
  localparam int unsigned MAC_HIGH_EXT_W = 22;
  // Cycles to enter power-down, counted from the issue cycle
  localparam logic [1:0] SLEEP_CYCLES = 2'h3;
  localparam logic [1:0] CNT_ZERO = 2'h0;

  // ----------------------------------------
  // Opcode patterns (high nibble with low byte or low nibble, and one full word)
  // ----------------------------------------
  localparam logic [3:0] GRP_0 = 4'h0;
  localparam logic [3:0] GRP_3 = 4'h3;
  localparam logic [3:0] GRP_4 = 4'h4;
  localparam logic [7:0] LB_SHR1 = 8'h01;
  localparam logic [7:0] LB_SHR2 = 8'h09;
  localparam logic [7:0] LB_SHR8 = 8'h19;
  localparam logic [7:0] LB_SHR16 = 8'h29;
  localparam logic [7:0] LB_STC_SR = 8'h02;
  localparam logic [7:0] LB_STC_GBR = 8'h12;
  localparam logic [7:0] LB_STC_VBR = 8'h22;
  localparam logic [7:0] LB_PSH_SR = 8'h03;
  localparam logic [7:0] LB_PSH_GBR = 8'h13;
  localparam logic [7:0] LB_PSH_VBR = 8'h23;
  localparam logic [7:0] LB_STS_MAC_HIGH = 8'h0A;
  localparam logic [7:0] LB_STS_MAC_LOW = 8'h1A;
  localparam logic [7:0] LB_STS_PR = 8'h2A;
  localparam logic [7:0] LB_PSS_MAC_HIGH = 8'h02;
  localparam logic [7:0] LB_PSS_MAC_LOW = 8'h12;
  localparam logic [7:0] LB_PSS_PR = 8'h22;
  localparam logic [15:0] OP_SLEEP = 16'h001B;
  localparam logic [3:0] SUB_LO = 4'h8;
  localparam logic [3:0] MINUS_WITH_BORROW_OP_LO = 4'hA;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    RSX_IDLE = 2'b00,
    RSX_PUSH = 2'b01,
    RSX_ENTER = 2'b11,
    RSX_SLEEP = 2'b10
  } rsx_state_t;

  typedef struct packed {
    logic [31:0] status_word;
    logic [31:0] global_base_reg;
    logic [31:0] vector_base_reg;
    logic [31:0] mac_high;
    logic [31:0] mac_low;
    logic [31:0] return_link_reg;
  } rsx_ctl_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } rsx_mem_t;

  typedef struct packed {
    rsx_state_t state;
    logic [1:0] cnt;
    logic [31:0] pc;
    logic carry_flag;
    logic irq_block;
    logic busy;
    logic exc_start;
    rsx_mem_t mem;
    logic [31:0] push_data;
  } rsx_regs_t;
endpackage

// ==== design/rsx_exec.sv ====
// Execution slice: logical right shifts, power-down, control/system register
// stores (to a register or pushed to memory) and plain/borrow subtraction.
// Assumes the fetch stage presents one instruction per issue pulse and holds
// off while busy; the memory bus accepts a write in the cycle it is offered.
`timescale 1ns/100ps

module rsx_exec #(
  parameter bit NARROW_MAC = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Instruction issue
  input wire logic issue,
  input wire logic [15:0] instr,
  // General register file read ports
  output logic [3:0] dest_idx,
  output logic [3:0] src_idx,
  input wire logic [31:0] dest_val,
  input wire logic [31:0] src_val,
  // General register file write port
  output logic reg_we,
  output logic [3:0] reg_waddr,
  output logic [31:0] reg_wdata,
  // Control and system registers
  input wire rsx_pkg::rsx_ctl_t ctl,
  // Memory write port
  output rsx_pkg::rsx_mem_t mem_wr,
  // Interrupt and address error inputs
  input wire logic irq_req,
  input wire logic addr_err,
  // Status
  output logic busy,
  output logic power_down,
  output logic irq_accept,
  output logic addr_err_accept,
  output logic exc_start,
  output logic carry_flag,
  output logic [31:0] pc,
  output logic decode_hit
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic op_is(input logic [15:0] op, input logic [3:0] grp,
                                 input logic [7:0] lb);
    op_is = (op[15:12] == grp) && (op[7:0] == lb);
  endfunction

  function automatic logic [31:0] mac_high_view(input logic [31:0] v, input bit narrow);
    if (narrow)
    begin
      mac_high_view = {{rsx_pkg::MAC_HIGH_EXT_W{v[rsx_pkg::MAC_HIGH_SIGN_BIT]}},
                   v[rsx_pkg::MAC_HIGH_SIGN_BIT:0]};
    end
    else
    begin
      mac_high_view = v;
    end
  endfunction

  rsx_pkg::rsx_regs_t r_ff;
  rsx_pkg::rsx_regs_t nxt_r;

  logic d_shr1, d_shr2, d_shr8, d_shr16;
  logic d_stc_sr, d_stc_gbr, d_stc_vbr;
  logic d_psh_sr, d_psh_gbr, d_psh_vbr;
  logic d_sts_mac_high, d_sts_mac_low, d_sts_pr;
  logic d_pss_mac_high, d_pss_mac_low, d_pss_pr;
  logic d_sleep, d_sub, d_minus_with_borrow_op, d_any;
  logic [31:0] diff;
  logic [31:0] minus_with_borrow_op_res;
  logic bor1, bor2;
  logic [31:0] push_addr;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb
  begin
    d_shr1 = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_SHR1);
    d_shr2 = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_SHR2);
    d_shr8 = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_SHR8);
    d_shr16 = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_SHR16);
    d_stc_sr = op_is(instr, rsx_pkg::GRP_0, rsx_pkg::LB_STC_SR);
    d_stc_gbr = op_is(instr, rsx_pkg::GRP_0, rsx_pkg::LB_STC_GBR);
    d_stc_vbr = op_is(instr, rsx_pkg::GRP_0, rsx_pkg::LB_STC_VBR);
    d_psh_sr = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_PSH_SR);
    d_psh_gbr = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_PSH_GBR);
    d_psh_vbr = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_PSH_VBR);
    d_sts_mac_high = op_is(instr, rsx_pkg::GRP_0, rsx_pkg::LB_STS_MAC_HIGH);
    d_sts_mac_low = op_is(instr, rsx_pkg::GRP_0, rsx_pkg::LB_STS_MAC_LOW);
    d_sts_pr = op_is(instr, rsx_pkg::GRP_0, rsx_pkg::LB_STS_PR);
    d_pss_mac_high = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_PSS_MAC_HIGH);
    d_pss_mac_low = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_PSS_MAC_LOW);
    d_pss_pr = op_is(instr, rsx_pkg::GRP_4, rsx_pkg::LB_PSS_PR);
    d_sleep = (instr == rsx_pkg::OP_SLEEP);
    d_sub = (instr[15:12] == rsx_pkg::GRP_3) && (instr[3:0] == rsx_pkg::SUB_LO);
    d_minus_with_borrow_op = (instr[15:12] == rsx_pkg::GRP_3) && (instr[3:0] == rsx_pkg::MINUS_WITH_BORROW_OP_LO);
    d_any = d_shr1 | d_shr2 | d_shr8 | d_shr16 | d_stc_sr | d_stc_gbr | d_stc_vbr
          | d_psh_sr | d_psh_gbr | d_psh_vbr | d_sts_mac_high | d_sts_mac_low | d_sts_pr
          | d_pss_mac_high | d_pss_mac_low | d_pss_pr | d_sleep | d_sub | d_minus_with_borrow_op;
  end

  assign dest_idx = instr[11:8];
  assign src_idx = instr[7:4];
  assign decode_hit = issue && d_any;

  // ----------------------------------------
  // Arithmetic
  // ----------------------------------------
  always_comb
  begin
    diff = dest_val - src_val;
    bor1 = dest_val < diff;
    minus_with_borrow_op_res = diff - {31'h0000_0000, r_ff.carry_flag};
    bor2 = diff < minus_with_borrow_op_res;
    push_addr = dest_val - rsx_pkg::PUSH_STEP;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.mem.valid = 1'b0;
    nxt_r.exc_start = 1'b0;
    reg_we = 1'b0;
    reg_waddr = instr[11:8];
    reg_wdata = rsx_pkg::WORD_ZERO;
    // Interrupts are held off from the cycle after any store; cleared by next issue
    if (issue && r_ff.state == rsx_pkg::RSX_IDLE)
    begin
      nxt_r.irq_block = 1'b0;
    end
    case (r_ff.state)
      rsx_pkg::RSX_IDLE:
      begin
        if (issue && d_any)
        begin
          nxt_r.pc = r_ff.pc + rsx_pkg::PC_STEP;
          if (d_shr1)
          begin
            reg_we = 1'b1;
            reg_wdata = {1'b0, dest_val[31:1]};
            nxt_r.carry_flag = dest_val[0];
          end
          else if (d_shr2 | d_shr8 | d_shr16)
          begin
            reg_we = 1'b1;
            // Zero fill; carry untouched
            if (d_shr2)
            begin
              reg_wdata = {2'b00, dest_val[31:2]};
            end
            else if (d_shr8)
            begin
              reg_wdata = (dest_val >> 8) & rsx_pkg::HI24_MASK;
            end
            else
            begin
              reg_wdata = (dest_val >> 16) & rsx_pkg::HI16_MASK;
            end
          end
          else if (d_stc_sr | d_stc_gbr | d_stc_vbr | d_sts_mac_high | d_sts_mac_low | d_sts_pr)
          begin
            reg_we = 1'b1;
            nxt_r.irq_block = 1'b1;
            if (d_stc_sr)
              reg_wdata = ctl.status_word;
            else if (d_stc_gbr)
              reg_wdata = ctl.global_base_reg;
            else if (d_stc_vbr)
              reg_wdata = ctl.vector_base_reg;
            else if (d_sts_mac_high)
              reg_wdata = mac_high_view(ctl.mac_high, NARROW_MAC);
            else if (d_sts_mac_low)
              reg_wdata = ctl.mac_low;
            else
              reg_wdata = ctl.return_link_reg;
          end
          else if (d_pss_mac_high | d_pss_mac_low | d_pss_pr)
          begin
            reg_we = 1'b1;
            reg_wdata = push_addr;
            nxt_r.irq_block = 1'b1;
            nxt_r.mem.valid = 1'b1;
            nxt_r.mem.addr = push_addr;
            if (d_pss_mac_high)
              nxt_r.mem.data = mac_high_view(ctl.mac_high, NARROW_MAC);
            else if (d_pss_mac_low)
              nxt_r.mem.data = ctl.mac_low;
            else
              nxt_r.mem.data = ctl.return_link_reg;
          end
          else if (d_psh_sr | d_psh_gbr | d_psh_vbr)
          begin
            // Decrement now, write in the third cycle
            reg_we = 1'b1;
            reg_wdata = push_addr;
            nxt_r.irq_block = 1'b1;
            nxt_r.mem.addr = push_addr;
            if (d_psh_sr)
              nxt_r.push_data = ctl.status_word;
            else if (d_psh_gbr)
              nxt_r.push_data = ctl.global_base_reg;
            else
              nxt_r.push_data = ctl.vector_base_reg;
            nxt_r.busy = 1'b1;
            nxt_r.state = rsx_pkg::RSX_PUSH;
          end
          else if (d_sleep)
          begin
            nxt_r.pc = r_ff.pc;
            nxt_r.busy = 1'b1;
            nxt_r.cnt = rsx_pkg::SLEEP_CYCLES - 2'h1;
            nxt_r.state = rsx_pkg::RSX_ENTER;
          end
          else if (d_sub)
          begin
            reg_we = 1'b1;
            reg_wdata = diff;
          end
          else
          begin
            reg_we = 1'b1;
            reg_wdata = minus_with_borrow_op_res;
            nxt_r.carry_flag = bor1 | bor2;
          end
        end
      end
      rsx_pkg::RSX_PUSH:
      begin
        nxt_r.mem.valid = 1'b1;
        nxt_r.mem.data = r_ff.push_data;
        nxt_r.busy = 1'b0;
        nxt_r.state = rsx_pkg::RSX_IDLE;
      end
      rsx_pkg::RSX_ENTER:
      begin
        // Entry transition only; waiting is not counted
        nxt_r.cnt = r_ff.cnt - 2'h1;
        if (r_ff.cnt == 2'h1)
        begin
          nxt_r.state = rsx_pkg::RSX_SLEEP;
        end
      end
      rsx_pkg::RSX_SLEEP:
      begin
        // Hold everything until a request arrives
        if (irq_req)
        begin
          nxt_r.exc_start = 1'b1;
          nxt_r.busy = 1'b0;
          nxt_r.state = rsx_pkg::RSX_IDLE;
        end
      end
      default:
      begin
        nxt_r.state = rsx_pkg::RSX_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      r_ff.state <= rsx_pkg::RSX_IDLE;
      r_ff.cnt <= rsx_pkg::CNT_ZERO;
      r_ff.pc <= rsx_pkg::PC_RESET;
      r_ff.carry_flag <= 1'b0;
      r_ff.irq_block <= 1'b0;
      r_ff.busy <= 1'b0;
      r_ff.exc_start <= 1'b0;
      r_ff.mem <= '0;
      r_ff.push_data <= rsx_pkg::WORD_ZERO;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mem_wr = r_ff.mem;
  assign busy = r_ff.busy;
  assign power_down = (r_ff.state == rsx_pkg::RSX_SLEEP);
  assign exc_start = r_ff.exc_start;
  assign carry_flag = r_ff.carry_flag;
  assign pc = r_ff.pc;
  // Blocking window lasts until the next instruction issues
  assign irq_accept = irq_req && !r_ff.irq_block && (r_ff.state == rsx_pkg::RSX_IDLE);
  assign addr_err_accept = addr_err;
endmodule

// ==== tb/rsx_props.sv ====
// Checker for the execution slice, watching only its top-level ports.
// Assumes the single sys_clk domain with synchronous srst.
`timescale 1ns/100ps
module rsx_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Issue, operands and writes
  input wire logic issue,
  input wire logic [15:0] instr,
  input wire logic [31:0] dest_val,
  input wire logic [31:0] src_val,
  input wire logic reg_we,
  input wire logic [31:0] reg_wdata,
  input wire rsx_pkg::rsx_mem_t mem_wr,
  input wire logic irq_req,
  input wire logic addr_err,
  // Status
  input wire logic busy,
  input wire logic power_down,
  input wire logic irq_accept,
  input wire logic addr_err_accept,
  input wire logic exc_start,
  input wire logic carry_flag,
  input wire logic [31:0] pc,
  input wire logic decode_hit
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  wire take = issue && decode_hit && !busy;
  wire [3:0] hi = instr[15:12];
  wire [7:0] lb = instr[7:0];
  wire st = (hi == 4'h0 && (instr[3:0] == 4'h2 || instr[3:0] == 4'hA))
    || (hi == 4'h4 && (instr[3:0] == 4'h2 || instr[3:0] == 4'h3));
  // Bit 32 is the combined borrow of both subtraction steps
  wire [32:0] diff = {1'b0, dest_val} - {1'b0, src_val} - {32'h0, carry_flag};

  chk_shr_one: assert property (
    take && hi == 4'h4 && lb == 8'h01 |-> reg_we && reg_wdata == {1'b0, dest_val[31:1]}
    ##1 carry_flag == $past(dest_val[0])) else $error("one-bit shift wrong");
  chk_shr_eight: assert property (
    take && hi == 4'h4 && lb == 8'h19 |-> reg_wdata == {8'h00, dest_val[31:8]}
    ##1 carry_flag == $past(carry_flag)) else $error("eight-bit shift wrong");
  chk_pc_step: assert property (
    take && instr != rsx_pkg::OP_SLEEP |=> pc == $past(pc) + 32'h2)
    else $error("pc did not step by two");
  chk_sleep_entry: assert property (
    take && instr == rsx_pkg::OP_SLEEP |=> busy && pc == $past(pc) ##2 power_down)
    else $error("power-down entry wrong");
  chk_sleep_halt: assert property (
    power_down && !irq_req |-> !reg_we && !mem_wr.valid ##1 power_down)
    else $error("activity in power-down");
  chk_wake_exc: assert property (
    power_down && irq_req |=> exc_start && !power_down && !busy)
    else $error("wake-up wrong");
  chk_push_sys: assert property (
    take && hi == 4'h4 && instr[3:0] == 4'h2 |-> reg_wdata == dest_val - 32'h4
    ##1 mem_wr.valid && mem_wr.addr == $past(dest_val) - 32'h4)
    else $error("system push wrong");
  chk_push_ctl: assert property (
    take && hi == 4'h4 && instr[3:0] == 4'h3 |=> busy && !mem_wr.valid
    ##1 mem_wr.valid && !busy && mem_wr.addr == $past(dest_val, 2) - 32'h4)
    else $error("control push wrong");
  chk_irq_block: assert property (
    take && st |=> !irq_accept) else $error("interrupt taken after store");
  chk_addr_err: assert property (
    addr_err |-> addr_err_accept) else $error("address error refused");
  chk_minus_with_borrow_op_borrow: assert property (
    take && hi == 4'h3 && instr[3:0] == 4'hA |-> reg_wdata == diff[31:0]
    ##1 carry_flag == $past(diff[32])) else $error("borrow subtract wrong");

  cover property (take && instr == rsx_pkg::OP_SLEEP);
  cover property (power_down && irq_req);
  cover property (mem_wr.valid);
endmodule

bind rsx_exec rsx_props i_rsx_props (.sys_clk, .srst, .issue, .instr, .dest_val, .src_val,
  .reg_we, .reg_wdata, .mem_wr, .irq_req, .addr_err, .busy, .power_down, .irq_accept,
  .addr_err_accept, .exc_start, .carry_flag, .pc, .decode_hit);

// ==== tb/rsx_far_side.sv ====
// Far-side model: general register file and a memory that logs writes.
// Assumes combinational reads and writes landing on the clock edge.
`timescale 1ns/100ps
module rsx_far_side (
  // Clock
  input wire logic sys_clk,
  // Register file
  input wire logic [3:0] dest_idx,
  input wire logic [3:0] src_idx,
  output logic [31:0] dest_val,
  output logic [31:0] src_val,
  input wire logic reg_we,
  input wire logic [3:0] reg_waddr,
  input wire logic [31:0] reg_wdata,
  // Memory write port
  input wire rsx_pkg::rsx_mem_t mem_wr
);
  logic [31:0] gpr [16];
  logic [31:0] mem_addr;
  logic [31:0] mem_data;
  int mem_count = 0;
  assign dest_val = gpr[dest_idx];
  assign src_val = gpr[src_idx];
  always @(posedge sys_clk)
  begin
    if (reg_we)
      gpr[reg_waddr] <= reg_wdata;
    if (mem_wr.valid)
    begin
      mem_addr <= mem_wr.addr;
      mem_data <= mem_wr.data;
      mem_count <= mem_count + 1;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the execution slice and its far-side model.
// Assumes inputs move 1 ns after the rising edge of a 100 MHz clock.
`timescale 1ns/100ps
module testbench;
  localparam int LIMIT = 1000;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic issue = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic irq_req = 1'b0;
  logic addr_err = 1'b0;
  rsx_pkg::rsx_ctl_t ctl = {32'h5A5A_00F1, 32'hC0DE_0002, 32'h0000_0400,
    32'h8765_4321, 32'h1357_9BDF, 32'h0000_2468};
  rsx_pkg::rsx_mem_t mem_wr;
  logic [3:0] dest_idx, src_idx, reg_waddr;
  logic [31:0] dest_val, src_val, reg_wdata, pc;
  logic reg_we, busy, power_down, irq_accept, addr_err_accept, exc_start;
  logic carry_flag, decode_hit;
  logic [31:0] narrow_wdata;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  rsx_exec i_rsx_exec (.sys_clk, .srst, .issue, .instr, .dest_idx, .src_idx, .dest_val,
    .src_val, .reg_we, .reg_waddr, .reg_wdata, .ctl, .mem_wr, .irq_req, .addr_err, .busy,
    .power_down, .irq_accept, .addr_err_accept, .exc_start, .carry_flag, .pc, .decode_hit);
  // Narrow-accumulator build shares every input; only its register write data is watched
  rsx_exec #(.NARROW_MAC(1'b1)) i_rsx_exec_narrow (.sys_clk, .srst, .issue, .instr,
    .dest_idx(), .src_idx(), .dest_val, .src_val, .reg_we(), .reg_waddr(),
    .reg_wdata(narrow_wdata), .ctl, .mem_wr(), .irq_req, .addr_err, .busy(), .power_down(),
    .irq_accept(), .addr_err_accept(), .exc_start(), .carry_flag(), .pc(), .decode_hit());
  rsx_far_side i_rsx_far_side (.sys_clk, .dest_idx, .src_idx, .dest_val, .src_val,
    .reg_we, .reg_waddr, .reg_wdata, .mem_wr);

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input int n, input logic [31:0] v);
    i_rsx_far_side.gpr[n] = v;
  endtask
  function automatic logic [31:0] rg(input int n);
    return i_rsx_far_side.gpr[n];
  endfunction
  // Holds issue through one edge; consecutive calls give back-to-back issue
  task automatic op(input logic [15:0] w);
    issue = 1'b1;
    instr = w;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic idle(input int n);
    issue = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic t_shift();
    logic [31:0] p;
    p = pc;
    wr(1, 32'h8000_0001);
    for (int i = 2; i < 5; i++)
      wr(i, 32'h1234_5678);
    op(16'h4101);
    op(16'h4209);
    op(16'h4319);
    op(16'h4429);
    idle(1);
    cmp("shift one", 32'h4000_0000, rg(1));
    cmp("shift carry", 32'h1, carry_flag);
    cmp("shift two", 32'h048D_159E, rg(2));
    cmp("shift eight", 32'h0012_3456, rg(3));
    cmp("shift sixteen", 32'h0000_1234, rg(4));
    cmp("shift pc", p + 32'h8, pc);
  endtask
  // Carry enters at 1; plain subtract must not clear it before the borrow chain
  task automatic t_sub();
    wr(5, 32'h5);
    wr(6, 32'h1);
    wr(7, 32'h5);
    wr(8, 32'h1);
    wr(9, 32'h0);
    wr(10, 32'h1);
    wr(11, 32'h0);
    wr(12, 32'h0);
    op(16'h3568);
    op(16'h378A);
    op(16'h39AA);
    op(16'h3BCA);
    idle(1);
    cmp("sub", 32'h4, rg(5));
    cmp("minus_with_borrow_op in", 32'h3, rg(7));
    cmp("minus_with_borrow_op reg", 32'hFFFF_FFFF, rg(9));
    cmp("minus_with_borrow_op t", 32'hFFFF_FFFF, rg(11));
    cmp("minus_with_borrow_op carry", 32'h1, carry_flag);
  endtask
  task automatic t_store();
    logic [15:0] ops [6] = '{16'h0102, 16'h0212, 16'h0322, 16'h040A, 16'h051A, 16'h062A};
    irq_req = 1'b1;
    addr_err = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      issue = 1'b1;
      instr = ops[i];
      #1;
      if (i == 3)
        cmp("narrow mac_high", 32'hFFFF_FF21, narrow_wdata);
      @(posedge sys_clk);
      #1;
    end
    idle(0);
    cmp("irq held off", 32'h0, irq_accept);
    cmp("addr err", 32'h1, addr_err_accept);
    op(16'h4729);
    idle(0);
    cmp("irq released", 32'h1, irq_accept);
    irq_req = 1'b0;
    addr_err = 1'b0;
    for (int i = 0; i < 6; i++)
      cmp("store", ctl[191 - 32 * i -: 32], rg(i + 1));
  endtask
  task automatic t_push();
    logic [7:0] lbs [6] = '{8'h03, 8'h13, 8'h23, 8'h02, 8'h12, 8'h22};
    logic [31:0] a, p, r1;
    logic c;
    int n;
    c = carry_flag;
    a = 32'h1000_0004;
    wr(15, a);
    for (int i = 0; i < 6; i++)
    begin
      n = i_rsx_far_side.mem_count;
      r1 = rg(1);
      p = pc;
      a = a - 32'h4;
      op({8'h4F, lbs[i]});
      if (i < 3)
      begin
        cmp("push busy", 32'h1, busy);
        op(16'h4101);
      end
      idle(3);
      cmp("push addr", a, i_rsx_far_side.mem_addr);
      cmp("push data", ctl[191 - 32 * i -: 32], i_rsx_far_side.mem_data);
      cmp("push reg", a, rg(15));
      cmp("push count", 32'(n + 1), 32'(i_rsx_far_side.mem_count));
      cmp("push pc", p + 32'h2, pc);
      cmp("refused", r1, rg(1));
    end
    cmp("push carry", {31'h0, c}, carry_flag);
  endtask
  task automatic t_sleep();
    logic [31:0] p, r1;
    p = pc;
    r1 = rg(1);
    op(rsx_pkg::OP_SLEEP);
    idle(0);
    cmp("sleep busy", 32'h1, busy);
    cmp("sleep early", 32'h0, power_down);
    idle(2);
    cmp("sleep mode", 32'h1, power_down);
    op(16'h4101);
    idle(8);
    cmp("sleep pc", p, pc);
    cmp("sleep state", r1, rg(1));
    cmp("sleep held", 32'h1, power_down);
    irq_req = 1'b1;
    idle(1);
    cmp("wake exc", 32'h1, exc_start);
    cmp("wake mode", 32'h0, power_down);
    irq_req = 1'b0;
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    cmp("reset pc", rsx_pkg::PC_RESET, pc);
    t_shift();
    t_sub();
    t_store();
    t_push();
    t_sleep();
    complete_run();
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      complete_run();
    end
  end
endmodule
